// ==== common/msc_pkg.sv ====
// Package for the miscellaneous system counter register bank.
// Assumes one 100 MHz clock and a same-clock register port from the host bus logic.
package msc_pkg;
  // ==========================================================================
  // Register offsets (byte addresses)
  localparam logic [7:0] OFS_TIMER_CONFIG        = 8'h8C;
  localparam logic [7:0] OFS_TIMER_CURRENT_COUNT = 8'h90;
  localparam logic [7:0] OFS_HOST_WORD_SWAP      = 8'h98;
  localparam logic [7:0] OFS_FREE_RUNNING_COUNT  = 8'h9C;
  localparam logic [7:0] OFS_DROPPED_FRAME_COUNT = 8'hA0;
  // ==========================================================================
  // Field positions and reset values
  localparam int          TIMER_RUN_BIT     = 29;
  localparam int          PRELOAD_MSB       = 15;
  localparam logic [15:0] PRELOAD_RESET     = 16'hFFFF;
  localparam logic [15:0] LIVE_COUNT_RESET  = 16'hFFFF;
  localparam logic [31:0] SWAP_RESET        = 32'h0000_0000;
  localparam logic [31:0] SWAP_HIGH_LOW     = 32'hFFFF_FFFF;
  localparam logic [31:0] DROP_RESET        = 32'h0000_0000;
  localparam logic [31:0] DROP_BEFORE_HALF  = 32'h7FFF_FFFF;
  localparam logic [31:0] DROP_HALFWAY      = 32'h8000_0000;
  localparam logic [31:0] FREE_RUN_RESET    = 32'h0000_0000;
  // ==========================================================================
  // Timing: the 25 MHz count step derived from the 100 MHz clock
  localparam int          CLK_PERIOD_NS     = 10;
  localparam int          COUNT_PERIOD_NS   = 40;
  localparam int          TICK_CYCLES       = COUNT_PERIOD_NS / CLK_PERIOD_NS;
  localparam logic [1:0]  TICK_LAST         = 2'(TICK_CYCLES - 1);
  localparam int          FR_CLEAR_NS       = 160;
  localparam int          FR_CLEAR_CYCLES   = FR_CLEAR_NS / CLK_PERIOD_NS;
  // ==========================================================================
  // Pin function encodings
  typedef enum logic [2:0] {
    PF_SERIAL_MEMORY = 3'b000,
    PF_GENERAL_OUTPUT_THREE_GENERAL_OUTPUT_FOUR     = 3'b001,
    PF_RSVD_A        = 3'b010,
    PF_GENERAL_OUTPUT_THREE_RXDV     = 3'b011,
    PF_RSVD_B        = 3'b100,
    PF_TXEN_GENERAL_OUTPUT_FOUR     = 3'b101,
    PF_TXEN_RXDV     = 3'b110,
    PF_TXCLK_RXCLK   = 3'b111
  } msc_pin_func_type;
  // ==========================================================================
  // Register port request carrier
  typedef struct packed {
    logic        rd;
    logic        wr;
    logic        width16;
    logic [7:0]  addr;
    logic [31:0] wdata;
  } msc_req_type;
  // Network debug signals that may be routed to the serial memory pins
  typedef struct packed {
    logic tx_en;
    logic tx_clk;
    logic rx_dv;
    logic rx_clk;
  } msc_dbg_type;
endpackage : msc_pkg

// ==== hw/msc_regs.sv ====
// Miscellaneous system register bank: pin function select, timer, word swap,
// free-running counter and dropped frame counter.
// Assumes a same-clock register port, pin input still asynchronous.
`timescale 1ns/1ps
`default_nettype none

module msc_regs (
  input  wire logic                 clk,
  input  wire logic                 reset_n,
  input  wire msc_pkg::msc_req_type req,
  output var  logic [31:0]          rdata,
  output var  logic                 rvalid,
  input  wire logic                 frame_dropped,
  input  wire msc_pkg::msc_dbg_type dbg,
  input  wire logic                 general_output_three,
  input  wire logic                 general_output_four,
  input  wire logic                 sm_data_out,
  input  wire logic                 sm_data_oe_n,
  input  wire logic                 sm_clock_out,
  output var  logic                 sm_data_in,
  input  wire logic                 serial_memory_data_pin_i,
  output var  logic                 serial_memory_data_pin_o,
  output var  logic                 serial_memory_data_pin_oe_n,
  output var  logic                 serial_memory_clock_pin,
  input  wire logic [2:0]           pin_function_select,
  output var  logic                 timer_event,
  output var  logic                 drop_half_event
);

  // ==========================================================================
  // State
  typedef struct packed {
    logic        run;
    logic [15:0] preload;
    logic [15:0] live;
    logic [31:0] swap;
    logic [31:0] free_run;
    logic [31:0] fr_latch;
    logic        fr_held;
    logic [31:0] drops;
    logic [1:0]  prescale;
    logic [31:0] rdata;
    logic        rvalid;
    logic        pin_sync1;
    logic        pin_sync2;
    logic        data_o;
    logic        data_oe_n;
    logic        clock_o;
    logic        timer_ev;
    logic        half_ev;
  } msc_state_type;

  msc_state_type s_q;
  msc_state_type s_d;

  // ==========================================================================
  // Helpers
  // Merge a 16-bit host write into one half of a word
  function automatic logic [31:0] msc_merge(input logic [31:0] old, input logic [31:0] wd,
                                            input logic w16, input logic hi);
    logic [31:0] r;
    r = wd;
    if (w16) begin
      r = hi ? {wd[15:0], old[15:0]} : {old[31:16], wd[15:0]};
    end
    return r;
  endfunction : msc_merge

  logic        tick;
  logic        hi_half;
  logic [31:0] cfg_word;
  logic [31:0] cfg_new;
  logic [31:0] rd_word;
  logic        rd_hit_fr;
  logic        rd_hit_drop;

  // ==========================================================================
  // Next state
  always_comb begin
    s_d  = s_q;
    tick = (s_q.prescale == msc_pkg::TICK_LAST);
    // Half select only matters on a 16-bit bus; 32-bit ignores swap
    hi_half = req.addr[1] ^ (s_q.swap == msc_pkg::SWAP_HIGH_LOW);
    cfg_word = {2'b00, s_q.run, 13'h0000, s_q.preload};
    cfg_new  = msc_merge(cfg_word, req.wdata, req.width16, hi_half);
    rd_hit_fr   = req.rd && (req.addr[7:2] == msc_pkg::OFS_FREE_RUNNING_COUNT[7:2]);
    rd_hit_drop = req.rd && (req.addr[7:2] == msc_pkg::OFS_DROPPED_FRAME_COUNT[7:2]);

    // Free counter never gated by power state, only by reset
    s_d.prescale = tick ? 2'h0 : 2'(s_q.prescale + 2'h1);
    if (tick) begin
      s_d.free_run = s_q.free_run + 32'h0000_0001; // wraps naturally
    end

    // Timer run and preload writes
    s_d.timer_ev = 1'b0;
    if (req.wr && req.addr[7:2] == msc_pkg::OFS_TIMER_CONFIG[7:2]) begin
      s_d.run     = cfg_new[msc_pkg::TIMER_RUN_BIT];
      s_d.preload = cfg_new[msc_pkg::PRELOAD_MSB:0];
      if (!s_q.run && s_d.run) begin
        s_d.live = s_d.preload; // start from the fresh preload
      end
    end
    if (s_q.run && !s_d.run) begin
      s_d.preload = msc_pkg::PRELOAD_RESET;
    end
    if (s_q.run && s_d.run && tick) begin
      if (s_q.live == 16'h0000) begin
        s_d.live     = s_q.preload;
        s_d.timer_ev = 1'b1;
      end else begin
        s_d.live = s_q.live - 16'h0001;
      end
    end

    // Word swap register; network word order is untouched by it
    if (req.wr && req.addr[7:2] == msc_pkg::OFS_HOST_WORD_SWAP[7:2]) begin
      s_d.swap = msc_merge(s_q.swap, req.wdata, req.width16, hi_half);
    end

    // Drop counter: a drop in the read cycle survives the clear
    s_d.half_ev = 1'b0;
    if (rd_hit_drop) begin
      s_d.drops = frame_dropped ? 32'h0000_0001 : 32'h0000_0000;
    end else if (frame_dropped) begin
      s_d.drops   = s_q.drops + 32'h0000_0001;
      s_d.half_ev = (s_q.drops == msc_pkg::DROP_BEFORE_HALF);
    end

    // Read mux
    unique case (req.addr & 8'hFC)
      msc_pkg::OFS_TIMER_CONFIG:        rd_word = cfg_word;
      msc_pkg::OFS_TIMER_CURRENT_COUNT: rd_word = {16'h0000, s_q.live};
      msc_pkg::OFS_HOST_WORD_SWAP:      rd_word = s_q.swap;
      msc_pkg::OFS_FREE_RUNNING_COUNT:  rd_word = s_q.free_run;
      msc_pkg::OFS_DROPPED_FRAME_COUNT: rd_word = s_q.drops;
      default:                          rd_word = 32'h0000_0000;
    endcase
    // First 16-bit read latches the count, second returns the latch
    if (rd_hit_fr && req.width16) begin
      s_d.fr_held = !s_q.fr_held;
      if (!s_q.fr_held) begin
        s_d.fr_latch = s_q.free_run;
      end else begin
        rd_word = s_q.fr_latch;
      end
    end
    s_d.rvalid = req.rd;
    if (req.rd) begin
      s_d.rdata = req.width16 ? {16'h0000, hi_half ? rd_word[31:16] : rd_word[15:0]}
                              : rd_word;
    end

    // Pin routing, registered so the pins come from flops
    s_d.pin_sync1 = serial_memory_data_pin_i;
    s_d.pin_sync2 = s_q.pin_sync1;
    s_d.data_oe_n = 1'b0;
    case (msc_pkg::msc_pin_func_type'(pin_function_select))
      msc_pkg::PF_SERIAL_MEMORY: begin
        s_d.data_o    = sm_data_out;
        s_d.data_oe_n = sm_data_oe_n;
        s_d.clock_o   = sm_clock_out;
      end
      msc_pkg::PF_GENERAL_OUTPUT_THREE_GENERAL_OUTPUT_FOUR: begin
        s_d.data_o  = general_output_three;
        s_d.clock_o = general_output_four;
      end
      msc_pkg::PF_GENERAL_OUTPUT_THREE_RXDV: begin
        s_d.data_o  = general_output_three;
        s_d.clock_o = dbg.rx_dv;
      end
      msc_pkg::PF_TXEN_GENERAL_OUTPUT_FOUR: begin
        s_d.data_o  = dbg.tx_en;
        s_d.clock_o = general_output_four;
      end
      msc_pkg::PF_TXEN_RXDV: begin
        s_d.data_o  = dbg.tx_en;
        s_d.clock_o = dbg.rx_dv;
      end
      msc_pkg::PF_TXCLK_RXCLK: begin
        s_d.data_o  = dbg.tx_clk;
        s_d.clock_o = dbg.rx_clk;
      end
      // Reserved codes: park the data pin undriven, clock low
      default: begin
        s_d.data_o    = 1'b0;
        s_d.data_oe_n = 1'b1;
        s_d.clock_o   = 1'b0;
      end
    endcase
  end

  // ==========================================================================
  // State register; clears in one edge, well inside the allowed 160 ns
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      s_q           <= '0;
      s_q.preload   <= msc_pkg::PRELOAD_RESET;
      s_q.live      <= msc_pkg::LIVE_COUNT_RESET;
      s_q.swap      <= msc_pkg::SWAP_RESET;
      s_q.free_run  <= msc_pkg::FREE_RUN_RESET;
      s_q.drops     <= msc_pkg::DROP_RESET;
      s_q.data_oe_n <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs straight from flops
  assign rdata                       = s_q.rdata;
  assign rvalid                      = s_q.rvalid;
  assign sm_data_in                  = s_q.pin_sync2;
  assign serial_memory_data_pin_o    = s_q.data_o;
  assign serial_memory_data_pin_oe_n = s_q.data_oe_n;
  assign serial_memory_clock_pin     = s_q.clock_o;
  assign timer_event                 = s_q.timer_ev;
  assign drop_half_event             = s_q.half_ev;

  // ==========================================================================
  // Assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  AST_PRELOAD_FORCE: assert property ($fell(s_q.run) |-> s_q.preload == 16'hFFFF)
    else $error("preload not forced on run clear");
  AST_RUN_SET: assert property (req.wr && !req.width16 && req.addr == 8'h8C
                                && req.wdata[29] |=> s_q.run)
    else $error("run bit not set by write");
  AST_TIMER_RELOAD: assert property (s_q.run && tick && s_q.live == 16'h0000
                                     && !req.wr |=> timer_event
                                     && s_q.live == $past(s_q.preload))
    else $error("timer did not reload and flag at zero");
  AST_TIMER_STEP: assert property (s_q.run && tick && s_q.live != 16'h0000 && !req.wr
                                   |=> s_q.live == $past(s_q.live) - 16'h0001)
    else $error("timer did not decrement");
  AST_FR_STEP: assert property (tick |=> s_q.free_run == $past(s_q.free_run) + 32'h1)
    else $error("free counter missed a step");
  AST_FR_RATE: assert property (tick |=> !tick ##1 !tick ##1 !tick ##1 tick)
    else $error("free counter step not every four cycles");
  AST_DROP_CLR: assert property (rd_hit_drop && !frame_dropped |=> s_q.drops == 32'h0)
    else $error("drop counter not cleared by read");
  AST_DROP_INC: assert property (frame_dropped && !req.rd
                                 |=> s_q.drops == $past(s_q.drops) + 32'h1)
    else $error("drop counter did not increment");
  AST_HALFWAY: assert property (s_q.drops == 32'h8000_0000 && $past(s_q.drops) == 32'h7FFF_FFFF
                                |-> drop_half_event)
    else $error("no halfway event");
  AST_MUX_CLK: assert property (pin_function_select == 3'b111
                                |=> serial_memory_clock_pin == $past(dbg.rx_clk))
    else $error("clock pin not routed to receive clock");
  AST_LIVE_READ: assert property (req.rd && !req.width16 && req.addr == 8'h90
                                  |=> rvalid && rdata == {16'h0, $past(s_q.live)})
    else $error("live count read mismatch");

  // ==========================================================================
  // Further checks on the register port, timer and pin path

  // A 32-bit write lands whole, whatever the swap setting
  AST_SWAP_WRITE32: assert property (req.wr && !req.width16 && req.addr == 8'h98
                                     |=> s_q.swap == $past(req.wdata))
    else $error("32-bit swap write not whole word");

  // Normal swap: upper half address returns the high word
  AST_HALF_NORMAL: assert property (req.rd && req.width16 && req.addr == 8'h9A
                                    && s_q.swap != 32'hFFFF_FFFF
                                    |=> rdata == {16'h0000, $past(s_q.swap[31:16])})
    else $error("16-bit upper half read wrong word");

  // All-ones swap: upper half address returns the low word
  AST_HALF_SWAPPED: assert property (req.rd && req.width16 && req.addr == 8'h9A
                                     && s_q.swap == 32'hFFFF_FFFF
                                     |=> rdata == {16'h0000, $past(s_q.swap[15:0])})
    else $error("16-bit swapped read wrong word");

  // First 16-bit read captures the running count
  AST_FR_LATCH: assert property (rd_hit_fr && req.width16 && !s_q.fr_held
                                 |=> s_q.fr_held && s_q.fr_latch == $past(s_q.free_run))
    else $error("free count not captured on first half read");

  // Second 16-bit read leaves the capture untouched
  AST_FR_HOLD: assert property (rd_hit_fr && req.width16 && s_q.fr_held
                                |=> !s_q.fr_held && s_q.fr_latch == $past(s_q.fr_latch))
    else $error("free count capture disturbed by second read");

  // A drop in the read cycle is not lost by the clear
  AST_DROP_SURVIVE: assert property (rd_hit_drop && frame_dropped
                                     |=> s_q.drops == 32'h0000_0001)
    else $error("drop lost in clearing read");

  // Starting the timer loads the written preload
  AST_START_LOAD: assert property (req.wr && !req.width16 && req.addr == 8'h8C
                                   && req.wdata[29] && !s_q.run
                                   |=> s_q.live == $past(req.wdata[15:0]))
    else $error("timer start did not load preload");

  // A halted timer keeps its count
  AST_HALT_HOLD: assert property (!s_q.run && !req.wr |=> s_q.live == $past(s_q.live))
    else $error("halted timer changed its count");

  // Reserved codes park the pins
  AST_RSVD_PARK: assert property (pin_function_select == 3'b010
                                  || pin_function_select == 3'b100
                                  |=> serial_memory_data_pin_oe_n && !serial_memory_clock_pin)
    else $error("reserved code did not park pins");

  // General output code drives the data pin
  AST_GPO_ROUTE: assert property (pin_function_select == 3'b001
                                  |=> !serial_memory_data_pin_oe_n
                                  && serial_memory_data_pin_o == $past(general_output_three))
    else $error("data pin not routed to general output");

  // Pin level passes exactly two flops, so metastability settles first
  AST_SYNC_PATH: assert property (reset_n ##1 reset_n
                                  |=> sm_data_in == $past(serial_memory_data_pin_i, 2))
    else $error("data pin sync latency wrong");

  // No answer without a read
  AST_RD_PULSE: assert property (!req.rd |=> !rvalid)
    else $error("read valid without a read");

  COV_TIMER_WRAP: cover property (timer_event);
  COV_HALFWAY:    cover property (drop_half_event);
  COV_FR_16BIT:   cover property (rd_hit_fr && req.width16 ##[1:20] rd_hit_fr && req.width16);
  COV_SWAPPED:    cover property (s_q.swap == 32'hFFFF_FFFF && req.rd && req.width16);

endmodule : msc_regs

`default_nettype wire

// ==== dv/msc_host.sv ====
// Host model driving the register port of the register bank.
// Assumes rvalid answers a read one cycle after the taking edge.
`timescale 1ns/1ps
`default_nettype none
module msc_host (
  input  wire logic                 clk,
  output var  msc_pkg::msc_req_type req,
  input  wire logic [31:0]          rdata,
  input  wire logic                 rvalid
);
  // ==========================================================
  // Bus cycles
  initial req = '0;
  // Write: strobe one cycle, stale data inverted once released
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    req <= '{1'b0, 1'b1, 1'b0, a, d};
    @(posedge clk);
    req.wr    <= 1'b0;
    req.wdata <= ~d;
  endtask : wr
  // Read: bounded wait, x if rvalid never comes
  task automatic rd(input logic [7:0] a, input logic w16, output logic [31:0] d);
    int n = 0;
    @(posedge clk);
    req <= '{1'b1, 1'b0, w16, a, 32'h0};
    @(posedge clk);
    req.rd <= 1'b0;
    do begin
      @(posedge clk);
      n++;
    end while (rvalid !== 1'b1 && n < 4);
    d = (rvalid === 1'b1) ? rdata : 'x;
  endtask : rd
endmodule : msc_host
`default_nettype wire

// ==== dv/testbench.sv ====
// Self-checking bench for the miscellaneous register bank.
// Assumes msc_host drives the register port; pin level resolved here.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic                 clk, reset_n, rvalid, fdrop, g3, g4, sdo, soe_n, sco;
  logic                 sdi, pin_i, pin_o, pin_oe_n, cpin, ext, t_ev, h_ev;
  logic [31:0]          rdata, seed, v, w;
  logic [2:0]           pfs, e;
  msc_pkg::msc_req_type req;
  msc_pkg::msc_dbg_type dbg;
  int                   errors, cmp_count, n;
  // Legal selector codes only; reserved codes are never programmed
  localparam logic [2:0] PF_CODES [6] = '{3'h0, 3'h1, 3'h3, 3'h5, 3'h6, 3'h7};
  // ==========================================================
  // Clock, pin wire and instances
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  assign pin_i = pin_oe_n ? ext : pin_o; // Far end drives only when released
  msc_regs DUT (.clk(clk), .reset_n(reset_n), .req(req), .rdata(rdata),
    .rvalid(rvalid), .frame_dropped(fdrop), .dbg(dbg), .general_output_three(g3),
    .general_output_four(g4), .sm_data_out(sdo), .sm_data_oe_n(soe_n),
    .sm_clock_out(sco), .sm_data_in(sdi), .serial_memory_data_pin_i(pin_i),
    .serial_memory_data_pin_o(pin_o), .serial_memory_data_pin_oe_n(pin_oe_n),
    .serial_memory_clock_pin(cpin), .pin_function_select(pfs),
    .timer_event(t_ev), .drop_half_event(h_ev));
  msc_host host (.clk(clk), .req(req), .rdata(rdata), .rvalid(rvalid));
  // ==========================================================
  // Helpers
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs
  // Expected {oe_n, data, clock} per selector code
  function automatic logic [2:0] pin_exp(input logic [2:0] c);
    case (c)
      3'h0: return {soe_n, sdo, sco};
      3'h1: return {1'b0, g3, g4};
      3'h3: return {1'b0, g3, dbg.rx_dv};
      3'h5: return {1'b0, dbg.tx_en, g4};
      3'h6: return {1'b0, dbg.tx_en, dbg.rx_dv};
      default: return {1'b0, dbg.tx_clk, dbg.rx_clk};
    endcase
  endfunction : pin_exp
  task automatic chk(input logic [31:0] g, input logic [31:0] x, input string m);
    cmp_count++;
    if (g !== x) begin
      errors++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, m, g, x);
    end
  endtask : chk
  task automatic drops(input int k);
    repeat (k) begin
      @(posedge clk);
      fdrop <= 1'b1;
      @(posedge clk);
      fdrop <= 1'b0;
    end
  endtask : drops
  // Cycles until the next timer pulse, capped so a silent timer ends
  task automatic wait_ev(output int c);
    c = 0;
    do begin
      @(posedge clk);
      c++;
    end while (t_ev !== 1'b1 && c < 400);
  endtask : wait_ev
  task automatic report_and_stop();
    $display("compares %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : report_and_stop
  // ==========================================================
  // Main sequence
  initial begin
    {reset_n, fdrop, g3, g4, sdo, soe_n, sco, ext, pfs, dbg} = '0;
    {errors, cmp_count} = '0;
    seed = 32'h0348E01E;
    repeat (6) @(posedge clk);
    reset_n <= 1'b1;
    host.rd(8'h8C, 1'b0, v);
    chk(v, 32'h0000FFFF, "cfg reset");
    host.wr(8'h90, 32'h1234);
    host.rd(8'h90, 1'b0, v);
    chk(v, 32'h0000FFFF, "live reset, RO");
    host.rd(8'h94, 1'b0, v);
    chk(v, 32'h0, "unmapped");
    $display("test reset done");
    // Timer: event every (preload+1) ticks of four clocks
    w = 32'h2 + xs() % 4;
    host.wr(8'h8C, 32'h2000_0000 | w);
    host.rd(8'h8C, 1'b0, v);
    chk(v, 32'h2000_0000 | w, "cfg run");
    wait_ev(n);
    wait_ev(n);
    chk(n, (w + 1) * 4, "timer period");
    host.rd(8'h90, 1'b0, v);
    chk(v <= w, 1, "live within preload");
    host.wr(8'h8C, 32'h7);
    host.rd(8'h8C, 1'b0, v);
    chk(v, 32'h0000FFFF, "halt forces preload");
    wait_ev(n);
    chk(n, 400, "halted");
    $display("test timer done");
    // Free counter: 43 clocks between reads is 10 or 11 ticks
    host.rd(8'h9C, 1'b0, v);
    repeat (40) @(posedge clk);
    host.rd(8'h9C, 1'b0, w);
    chk(w - v >= 10 && w - v <= 11, 1, "free rate");
    host.rd(8'h9C, 1'b1, v);
    repeat (20) @(posedge clk);
    host.rd(8'h9C, 1'b1, w);
    chk(w, v, "16-bit latch");
    $display("test free run done");
    // Drops count, then clear on read
    n = 1 + xs() % 20;
    drops(n);
    host.rd(8'hA0, 1'b0, v);
    chk(v, n, "drop count");
    host.rd(8'hA0, 1'b0, v);
    chk(v, 32'h0, "drop cleared");
    $display("test drops done");
    // Word swap in both bus modes
    host.wr(8'h98, 32'h1234_5678);
    host.rd(8'h98, 1'b0, v);
    chk(v, 32'h1234_5678, "32-bit map");
    host.rd(8'h98, 1'b1, v);
    chk(v, 32'h5678, "A1 low word");
    host.rd(8'h9A, 1'b1, v);
    chk(v, 32'h1234, "A1 high word");
    host.wr(8'h98, 32'hFFFF_FFFF);
    drops(3);
    host.rd(8'hA2, 1'b1, v);
    chk(v, 32'h3, "swapped A1 low");
    $display("test swap done");
    // Pin function: every legal code with random sources
    foreach (PF_CODES[i]) begin
      @(posedge clk);
      pfs <= PF_CODES[i];
      {dbg, g3, g4, sdo, soe_n, sco, ext} <= 10'(xs());
      repeat (2) @(posedge clk);
      e = pin_exp(pfs);
      chk({pin_oe_n, ~pin_oe_n & pin_o, cpin}, {e[2], ~e[2] & e[1], e[0]}, "pin");
      // Pin level reaches the serial memory side after two sync flops
      repeat (2) @(posedge clk);
      chk(sdi, pin_i, "data pin sync");
    end
    $display("test pins done");
    report_and_stop();
  end
  // Watchdog well beyond the several hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    report_and_stop();
  end
endmodule : testbench
`default_nettype wire
